// ### rtl/cpu_program_sequencer.sv
// program sequencer: phases, program counter, return stack and 8-bit alu
//
// What this block does
// - four non-overlapping phases make one instruction cycle
// - counter advances and fetch starts at first phase; rest execute
// - fetch overlaps execution; extended instructions take two cycles
// - counter-changing instructions take one extra cycle
// - counter increments by one unless control moves elsewhere
// - jump, call, interrupt and reset load destination into counter
// - met skip discards prefetched instruction, inserts dummy cycle
// - counter is high bits plus software-visible low byte
// - low byte write jumps within page and inserts dummy cycle
// - eight-level stack holds counter only, hidden from software
// - call and interrupt push counter; returns restore it
// - reset sets stack pointer to top of stack
// - interrupt while stack full is held pending until a return
// - call on full stack proceeds and loses the oldest entry
// - 8-bit alu on accumulator and data, result to chosen register
// - alu carry, borrow and other changes update status, except in the skip family
// - add, subtract, decimal adjust, logic, rotates, inc and dec
// - jumps, calls, returns and the skip family of decisions
// - reset starts execution at address zero
`timescale 1ns/100ps
module cpu_program_sequencer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input seq_pkg::instr_t instr_i,
  input wire logic irq_req_i,
  input wire logic irq_en_i,
  input wire logic [seq_pkg::PC_W-1:0] irq_vec_i,
  output logic [3:0] phase_o,
  output logic fetch_o,
  output logic [seq_pkg::PC_W-1:0] pmem_addr_o,
  output logic [7:0] pcl_o,
  output logic [7:0] acc_o,
  output seq_pkg::status_t status_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic irq_ack_o,
  output logic stack_full_o
);
  import seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] phase_r, phase_nxt;
  logic [3:0] phase_oh_r, phase_oh_nxt;
  seq_state_t state_r, state_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt, addr_r, addr_nxt;
  logic fetch_r, fetch_nxt;
  logic [7:0] acc_r, acc_nxt, wdata_r, wdata_nxt;
  status_t st_r, st_nxt;
  logic mem_wr_r, mem_wr_nxt;
  logic pend_r, pend_nxt, ack_r, ack_nxt;
  logic [2:0] wp_r, wp_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic full_r, full_nxt;
  logic [PC_W-1:0] stk_r [STK_DEPTH];
  logic push, exec_edge, redirect, take_irq;
  logic [PC_W-1:0] push_val;

  ////////////////////////////////////////////////////////////////////////
  // alu: result, status and zero test of the result
  function automatic logic [12:0] alu(input alu_op_t op,
    input logic [7:0] a, input logic [7:0] b, input status_t s);
    logic [7:0] r;
    logic [7:0] y;
    logic [8:0] sum;
    logic [4:0] half;
    logic ci;
    logic [7:0] adj;
    status_t n;
    r = a;
    n = s;
    y = (op == A_SUB || op == A_SBC) ? ~b : b;
    ci = (op == A_SUB) || ((op == A_ADC || op == A_SBC) && s.c);
    sum = {1'b0, a} + {1'b0, y} + {8'h00, ci};
    half = {1'b0, a[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    adj = 8'h00;
    case (op)
      A_PASS: r = b;
      A_ADD, A_ADC, A_SUB, A_SBC: begin
        r = sum[7:0];
        n.c = sum[8];
        n.ac = half[4];
        n.ov = (a[7] == y[7]) && (sum[7] != a[7]);
      end
      A_DAA: begin
        if (a[3:0] > BCD_MAX || s.ac) adj = adj | DAA_LO;
        if (a[7:4] > BCD_MAX || s.c) adj = adj | DAA_HI;
        sum = {1'b0, a} + {1'b0, adj};
        r = sum[7:0];
        n.c = sum[8] || s.c;
      end
      A_AND: r = a & b;
      A_OR: r = a | b;
      A_XOR: r = a ^ b;
      A_CPL: r = ~b;
      A_RR: r = {b[0], b[7:1]};
      A_RRC: begin
        r = {s.c, b[7:1]};
        n.c = b[0];
      end
      A_RL: r = {b[6:0], b[7]};
      A_RLC: begin
        r = {b[6:0], s.c};
        n.c = b[7];
      end
      A_INC: r = b + 8'h01;
      A_DEC: r = b - 8'h01;
      default: r = a;
    endcase
    // rotates leave the zero flag alone, as pure data moves
    if (op != A_RR && op != A_RL && op != A_RRC && op != A_RLC)
      n.z = (r == 8'h00);
    return {r, n, r == 8'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // phase sequencer
  always_comb begin
    phase_nxt = phase_r + 2'h1;
    phase_oh_nxt = PH_OH_T1 << phase_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      phase_r <= PH_T1;
      phase_oh_r <= PH_OH_T1;
    end else begin
      phase_r <= phase_nxt;
      phase_oh_r <= phase_oh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign exec_edge = (phase_r == PH_T3) && (state_r == S_EXEC);

  always_comb begin
    logic [12:0] ar;
    ar = alu(instr_i.alu_op, acc_r, instr_i.operand, st_r);
    state_nxt = state_r;
    pc_nxt = pc_r;
    addr_nxt = addr_r;
    fetch_nxt = 1'b0;
    acc_nxt = acc_r;
    st_nxt = st_r;
    mem_wr_nxt = 1'b0;
    wdata_nxt = wdata_r;
    ack_nxt = 1'b0;
    // set wins: a request in the acknowledge cycle stays pending
    pend_nxt = pend_r;
    wp_nxt = wp_r;
    cnt_nxt = cnt_r;
    push = 1'b0;
    push_val = pc_r;
    redirect = 1'b0;
    take_irq = 1'b0;
    // advance counter and fetch entering first phase
    // the extended second cycle fetches nothing
    if (phase_r == PH_T4 && state_r != S_EXT) begin
      addr_nxt = pc_r;
      pc_nxt = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
      fetch_nxt = 1'b1;
    end
    // dummy or held cycle lasts through the next T3
    // so that the instruction shown in that cycle is never committed
    if (phase_r == PH_T3 && state_r != S_EXEC) state_nxt = S_EXEC;
    // only the execute state commits results
    if (exec_edge) begin
      case (instr_i.kind)
        K_ALU: begin
          st_nxt = ar[4:1];
          if (instr_i.to_mem) begin
            mem_wr_nxt = 1'b1;
            wdata_nxt = ar[12:5];
          end else begin
            acc_nxt = ar[12:5];
          end
        end
        // skip family; met skip drops the prefetch
        K_SKIP: begin
          if (instr_i.alu_op != A_PASS) begin
            if (instr_i.to_mem) begin
              mem_wr_nxt = 1'b1;
              wdata_nxt = ar[12:5];
            end else begin
              acc_nxt = ar[12:5];
            end
          end
          redirect = ar[0] ^ instr_i.skip_nz;
        end
        K_JMP: begin
          pc_nxt = instr_i.target;
          redirect = 1'b1;
        end
        // push return address, even when full
        K_CALL: begin
          push = 1'b1;
          // return point is the prefetched word that the call drops
          push_val = addr_r;
          pc_nxt = instr_i.target;
          redirect = 1'b1;
        end
        K_RET, K_INTERRUPT_RETURN_OP: begin
          wp_nxt = wp_r - 3'h1;
          pc_nxt = stk_r[wp_nxt];
          if (cnt_r != STK_EMPTY) cnt_nxt = cnt_r - 4'h1;
          redirect = 1'b1;
        end
        // low byte write stays inside the page
        K_WR_PCL: begin
          pc_nxt = {pc_r[PC_W-1:PCL_W], instr_i.operand};
          redirect = 1'b1;
        end
        default: ;
      endcase
      // acknowledge only with room left on the stack
      take_irq = pend_r && irq_en_i && !redirect && !instr_i.ext
        && cnt_r != STK_FULL;
      if (take_irq) begin
        // return to the prefetched instruction that is dropped here
        push = 1'b1;
        push_val = addr_r;
        pc_nxt = irq_vec_i;
        ack_nxt = 1'b1;
        pend_nxt = 1'b0;
        redirect = 1'b1;
      end
      // counter change costs a dummy cycle
      if (redirect) state_nxt = S_DUMMY;
      else if (instr_i.ext) state_nxt = S_EXT;
    end
    if (push) begin
      wp_nxt = wp_r + 3'h1;
      if (cnt_r != STK_FULL) cnt_nxt = cnt_r + 4'h1;
    end
    if (irq_req_i) pend_nxt = 1'b1;
    full_nxt = (cnt_nxt == STK_FULL);
  end

  ////////////////////////////////////////////////////////////////////////
  // reset vector, empty stack, start with a dummy cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= S_DUMMY;
      pc_r <= RESET_VEC;
      addr_r <= RESET_VEC;
      fetch_r <= 1'b0;
      acc_r <= 8'h00;
      st_r <= '0;
      mem_wr_r <= 1'b0;
      wdata_r <= 8'h00;
      pend_r <= 1'b0;
      ack_r <= 1'b0;
      wp_r <= 3'h0;
      cnt_r <= STK_EMPTY;
      full_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      addr_r <= addr_nxt;
      fetch_r <= fetch_nxt;
      acc_r <= acc_nxt;
      st_r <= st_nxt;
      mem_wr_r <= mem_wr_nxt;
      wdata_r <= wdata_nxt;
      pend_r <= pend_nxt;
      ack_r <= ack_nxt;
      wp_r <= wp_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
    end
  end

  // circular store; a push on a full stack drops the oldest
  always_ff @(posedge clk_i) begin
    if (push) stk_r[wp_r] <= push_val;
  end

  assign phase_o = phase_oh_r;
  assign fetch_o = fetch_r;
  assign pmem_addr_o = addr_r;
  assign pcl_o = pc_r[PCL_W-1:0];
  assign acc_o = acc_r;
  assign status_o = st_r;
  assign mem_wr_o = mem_wr_r;
  assign mem_wdata_o = wdata_r;
  assign irq_ack_o = ack_r;
  assign stack_full_o = full_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_phase_onehot: assert property ($onehot(phase_o))
    else $error("phase outputs not one-hot");

  a_fetch_first_phase: assert property (
    fetch_o |-> phase_o == PH_OH_T1 && pc_r == pmem_addr_o + 14'h0001)
    else $error("fetch outside first phase or counter not advanced");

  a_ext_two_cycles: assert property (
    exec_edge && instr_i.ext && instr_i.kind == K_ALU && !take_irq
    |=> ##1 !fetch_o ##4 fetch_o)
    else $error("extended instruction did not hold fetch one cycle");

  a_redirect_dummy: assert property (
    exec_edge && redirect |=> state_r == S_DUMMY)
    else $error("redirect without dummy cycle");

  a_jump_target: assert property (
    exec_edge && instr_i.kind == K_JMP && !take_irq
    |=> pc_r == $past(instr_i.target) ##3 pmem_addr_o == $past(pc_r, 3))
    else $error("jump target not loaded and fetched");

  a_pcl_page: assert property (
    exec_edge && instr_i.kind == K_WR_PCL
    |=> pc_r == {$past(pc_r[PC_W-1:PCL_W]), $past(instr_i.operand)})
    else $error("low byte write left the page");

  a_call_depth: assert property (
    exec_edge && instr_i.kind == K_CALL
    |=> cnt_r == ($past(cnt_r) == STK_FULL ? STK_FULL : $past(cnt_r) + 4'h1))
    else $error("stack depth wrong after call");

  a_call_push: assert property (
    exec_edge && instr_i.kind == K_CALL
    |=> stk_r[$past(wp_r)] == $past(addr_r))
    else $error("call did not save the prefetched address");

  a_ack_room: assert property (
    irq_ack_o |-> $past(cnt_r) != STK_FULL && $past(pend_r))
    else $error("interrupt acknowledged on a full stack");

  a_dummy_quiet: assert property (
    phase_r == PH_T3 && state_r != S_EXEC
    |=> $stable(acc_o) && $stable(status_o) && !mem_wr_o && $stable(cnt_r))
    else $error("dummy cycle changed state");

  a_reset_start: assert property (
    $rose(rst_b_i) |-> pc_r == RESET_VEC && cnt_r == STK_EMPTY)
    else $error("reset did not clear counter and stack");
endmodule

// ### rtl/seq_pkg.sv
// constants, types and instruction layout for the program sequencer
package seq_pkg;
  localparam int PC_W = 14;
  localparam logic [PC_W-1:0] RESET_VEC = 14'h0000;
  localparam int STK_DEPTH = 8;
  localparam logic [3:0] STK_FULL = 4'h8;
  localparam logic [3:0] STK_EMPTY = 4'h0;
  localparam logic [1:0] PH_T1 = 2'h0;
  localparam logic [1:0] PH_T3 = 2'h2;
  localparam logic [1:0] PH_T4 = 2'h3;
  localparam logic [3:0] PH_OH_T1 = 4'h1;
  localparam logic [7:0] DAA_LO = 8'h06;
  localparam logic [7:0] DAA_HI = 8'h60;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam int PCL_W = 8;

  typedef enum logic [2:0] {
    K_NOP, K_ALU, K_SKIP, K_JMP, K_CALL, K_RET, K_INTERRUPT_RETURN_OP, K_WR_PCL
  } kind_t;

  typedef enum logic [3:0] {
    A_PASS, A_ADD, A_ADC, A_SUB, A_SBC, A_DAA, A_AND, A_OR,
    A_XOR, A_CPL, A_RR, A_RRC, A_RL, A_RLC, A_INC, A_DEC
  } alu_op_t;

  typedef struct packed {
    kind_t kind;
    alu_op_t alu_op;
    logic to_mem;
    logic ext;
    logic skip_nz;
    logic [PC_W-1:0] target;
    logic [7:0] operand;
  } instr_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } status_t;

  typedef enum logic [1:0] {S_EXEC, S_EXT, S_DUMMY} seq_state_t;
endpackage

// ### dv/tb.sv
// self-checking bench for the program sequencer
`timescale 1ns/100ps
module tb;
  import seq_pkg::*;
  logic clk_i, rst_b_i, irq_req_i, irq_en_i, fetch_o, mem_wr_o;
  logic irq_ack_o, stack_full_o, rq;
  instr_t instr_i;
  logic [PC_W-1:0] irq_vec_i, pmem_addr_o, last_f;
  logic [PC_W-1:0] ra [9];
  logic [3:0] phase_o, ph_q;
  logic [7:0] pcl_o, acc_o, mem_wdata_o, ea;
  status_t status_o, es;
  int n_errors, checks_done, seed, acks;
  localparam logic [PC_W-1:0] VEC = 14'h3f00;

  cpu_program_sequencer dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .instr_i(instr_i), .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
    .irq_vec_i(irq_vec_i), .phase_o(phase_o), .fetch_o(fetch_o),
    .pmem_addr_o(pmem_addr_o), .pcl_o(pcl_o), .acc_o(acc_o),
    .status_o(status_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .irq_ack_o(irq_ack_o), .stack_full_o(stack_full_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // skipped until one clock out of reset, phases are not yet moving
  always @(posedge clk_i) begin
    if (rq === 1'b1 && rst_b_i === 1'b1)
      chk(phase_o, {ph_q[2:0], ph_q[3]});
    if (fetch_o === 1'b1) begin
      chk(phase_o, PH_OH_T1);
      last_f <= pmem_addr_o;
    end
    if (irq_ack_o === 1'b1) acks <= acks + 1;
    ph_q <= phase_o;
    rq <= rst_b_i;
  end

  function automatic instr_t mk(kind_t k, alu_op_t o,
                                logic [PC_W-1:0] t, logic [7:0] d);
    mk = '0;
    mk.kind = k;
    mk.alu_op = o;
    mk.target = t;
    mk.operand = d;
  endfunction

  function automatic logic [11:0] model(alu_op_t o, logic [7:0] a,
                                        logic [7:0] b, status_t s);
    logic [7:0] r;
    logic [4:0] h;
    status_t n;
    r = 8'h00;
    h = 5'h00;
    n = s;
    case (o)
      A_ADD: {n.c, r} = a + b;
      A_ADC: {n.c, r} = a + b + s.c;
      A_SUB: {n.c, r} = a - b;
      A_SBC: {n.c, r} = a - b - !s.c;
      A_AND: r = a & b;
      A_OR: r = a | b;
      A_XOR: r = a ^ b;
      A_CPL: r = ~b;
      A_INC: r = b + 8'h01;
      A_DEC: r = b - 8'h01;
      A_RR: r = {b[0], b[7:1]};
      A_RL: r = {b[6:0], b[7]};
      A_RRC: begin r = {s.c, b[7:1]}; n.c = b[0]; end
      A_RLC: begin r = {b[6:0], s.c}; n.c = b[7]; end
      default: ;
    endcase
    // nibble carry and signed overflow of the add and subtract family
    if (o inside {A_ADD, A_ADC}) begin
      h = a[3:0] + b[3:0] + (o == A_ADC && s.c);
      n.ac = h[4];
      n.ov = (a[7] == b[7]) && (r[7] != a[7]);
    end
    if (o inside {A_SUB, A_SBC}) begin
      h = a[3:0] - b[3:0] - (o == A_SBC && !s.c);
      n.c = !n.c;
      n.ac = !h[4];
      n.ov = (a[7] != b[7]) && (r[7] != a[7]);
    end
    if (!(o inside {A_RR, A_RL, A_RRC, A_RLC})) n.z = (r == 8'h00);
    return {n, r};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // instr_i is only sampled at the end of T3; present it through T3, drop after
  task automatic run(input instr_t i);
    int n;
    n = 0;
    while (phase_o !== 4'b0010 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    @(posedge clk_i) instr_i <= i;
    @(posedge clk_i) instr_i <= '0;
    #1;
  endtask

  task automatic idle(input int c);
    repeat (4 * c) @(posedge clk_i) instr_i <= '0;
    #1;
  endtask

  task automatic nxt(output logic [PC_W-1:0] a);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (fetch_o !== 1'b1 && n < 20);
    a = pmem_addr_o;
  endtask

  // the target may already be fetched during the dummy cycle
  task automatic land(input logic [PC_W-1:0] t);
    logic [PC_W-1:0] a;
    a = last_f;
    for (int k = 0; k < 3 && a !== t; k++) nxt(a);
    chk(a, t);
    nxt(a);
    chk(a, t + 1'b1);
  endtask

  task automatic rst;
    logic [PC_W-1:0] a;
    @(posedge clk_i) rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk(acc_o, 8'h00);
    chk(stack_full_o, 1'b0);
    @(posedge clk_i) rst_b_i <= 1'b1;
    nxt(a);
    chk(a, RESET_VEC);
    ea = 8'h00;
    es = '0;
    $display("test reset finished");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    alu_op_t ops [14];
    alu_op_t o;
    instr_t in;
    logic [11:0] e;
    logic m;
    logic [7:0] d;
    ops = '{A_ADD, A_ADC, A_SUB, A_SBC, A_AND, A_OR, A_XOR,
      A_CPL, A_RR, A_RRC, A_RL, A_RLC, A_INC, A_DEC};
    seed = 80299;
    n_errors = 0;
    checks_done = 0;
    acks = 0;
    rq = 1'b0;
    ph_q = 4'h0;
    last_f = '0;
    rst_b_i = 1'b0;
    irq_req_i = 1'b0;
    irq_en_i = 1'b0;
    irq_vec_i = VEC;
    instr_i = '0;
    rst;
    for (int i = 0; i < 40; i++) begin
      o = ops[$unsigned($random(seed)) % 14];
      m = 1'($random(seed));
      d = 8'($random(seed));
      in = mk(K_ALU, o, '0, (i == 0) ? 8'hff : d);
      in.to_mem = m;
      e = model(o, ea, in.operand, es);
      run(in);
      chk(mem_wr_o, m);
      if (m) chk(mem_wdata_o, e[7:0]);
      else ea = e[7:0];
      chk(acc_o, ea);
      es = e[11:8];
      chk(status_o, es);
    end
    in = mk(K_ALU, A_DAA, '0, 8'h00);
    in.to_mem = 1'b1;
    run(in);
    chk(mem_wr_o, 1'b1);
    d = ea;
    if (ea[3:0] > 4'h9 || es.ac) d = d + 8'h06;
    if (ea[7:4] > 4'h9 || es.c) d = d + 8'h60;
    chk(mem_wdata_o, d);
    $display("test alu finished");
    for (int i = 0; i < 4; i++) begin
      in = mk(K_SKIP, A_PASS, '0, (i < 2) ? 8'h00 : 8'h05);
      in.skip_nz = i[0];
      run(in);
      run(mk(K_ALU, A_INC, '0, 8'h40 + 8'(i)));
      if (i == 1 || i == 2) ea = 8'h41 + 8'(i);
      chk(acc_o, ea);
      idle(2);
    end
    // increment-then-skip to memory: 0xff wraps to zero and skips
    in = mk(K_SKIP, A_INC, '0, 8'hff);
    in.to_mem = 1'b1;
    run(in);
    chk(mem_wr_o, 1'b1);
    chk(mem_wdata_o, 8'h00);
    run(mk(K_ALU, A_INC, '0, 8'h10));
    chk(acc_o, ea);
    idle(2);
    in = mk(K_ALU, A_ADD, '0, 8'h11);
    in.ext = 1'b1;
    run(in);
    ea = ea + 8'h11;
    run(mk(K_ALU, A_ADD, '0, 8'h22));
    chk(acc_o, ea);
    idle(2);
    run(mk(K_JMP, A_PASS, 14'h0a50, 8'h00));
    run(mk(K_ALU, A_INC, '0, 8'h7e));
    chk(acc_o, ea);
    land(14'h0a50);
    idle(2);
    run(mk(K_WR_PCL, A_PASS, '0, 8'h37));
    chk(pcl_o, 8'h37);
    run(mk(K_ALU, A_INC, '0, 8'h7e));
    chk(acc_o, ea);
    land(14'h0a37);
    $display("test redirect finished");
    for (int i = 0; i < 9; i++) begin
      if (i == 8) begin
        chk(stack_full_o, 1'b1);
        @(posedge clk_i) begin
          irq_req_i <= 1'b1;
          irq_en_i <= 1'b1;
        end
        @(posedge clk_i) irq_req_i <= 1'b0;
        idle(3);
        chk(acks, 0);
      end
      run(mk(K_CALL, A_PASS, 14'h1000 + 14'(i) * 14'h0100, 8'h00));
      ra[i] = last_f;
      idle(3);
    end
    chk(acks, 0);
    run(mk(K_RET, A_PASS, '0, 8'h00));
    land(ra[8]);
    land(VEC);
    chk(acks, 1);
    run(mk(K_INTERRUPT_RETURN_OP, A_PASS, '0, 8'h00));
    land(ra[8] + 1'b1);
    // oldest entry ra[0] was overwritten by the ninth call
    for (int i = 7; i > 0; i--) begin
      run(mk(K_RET, A_PASS, '0, 8'h00));
      land(ra[i]);
    end
    for (int i = 0; i < 8; i++) begin
      run(mk(K_CALL, A_PASS, 14'h2000, 8'h00));
      idle(3);
    end
    chk(stack_full_o, 1'b1);
    $display("test stack finished");
    rst;
    wrap_up;
  end
endmodule
